// File: adcrc_cfg.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ADCRC_CFG_SVH
`define ADCRC_CFG_SVH
`define ADCRC_OFF_SC1      8'h00
`define ADCRC_OFF_SC2      8'h04
`define ADCRC_OFF_RH       8'h08
`define ADCRC_OFF_RL       8'h0c
`define ADCRC_OFF_CVH      8'h10
`define ADCRC_OFF_CVL      8'h14
`define ADCRC_OFF_CFG      8'h18
`define ADCRC_OFF_IST      8'h1c
`define ADCRC_OFF_IMSK     8'h20
`define ADCRC_SC2_ACT_BIT  7
`define ADCRC_SC2_TRG_BIT  6
`define ADCRC_SC2_CFE_BIT  5
`define ADCRC_SC2_GE_BIT   4
`define ADCRC_SC1_CONV_COMPLETE_FLAG_BIT 7
`define ADCRC_CFG_MODE_LSB 2
`define ADCRC_MODE_8BIT    2'b00
`define ADCRC_MODE_10BIT   2'b10
`define ADCRC_CH_OFF       5'h1f
`define ADCRC_SC2_RST      8'h00
`define ADCRC_CV_RST       8'h00
`define ADCRC_CFG_RST      8'h00
`define ADCRC_CONV_NS      100
`define ADCRC_CLK_PS       4000
`define ADCRC_CONV_CYC     ((`ADCRC_CONV_NS * 1000 + `ADCRC_CLK_PS - 1) / `ADCRC_CLK_PS)
`define ADCRC_IRQ_DONE     0
`define ADCRC_IRQ_DROP     1
`endif

// File: adcrc_pkg.sv
// Types of the converter result and compare control
package adcrc_pkg;
  typedef enum logic [1:0] {
    ADCRC_IDLE = 2'b00,
    ADCRC_CONV = 2'b01
  } adcrc_state_e;
  typedef logic [9:0] adcrc_result_t;
endpackage : adcrc_pkg

// File: adcrc_ctrl.sv
// Converter result, compare and trigger control with AXI4-Lite registers
// Summary of operation
// - Active flag bit 7 set at conversion start, cleared at finish or abort.
// - Bit 6 selects start source: register write or hardware trigger.
// - Bit 5 enables the automatic compare function.
// - Bit 4: 0 less-than compare, 1 greater-or-equal compare.
// - Result-high holds top two bits; zero in 8-bit mode.
// - Results load each completion unless compare enabled and false, or results locked.
// - In 10-bit mode reading result-high locks results until result-low read.
// - Completion while locked discards that result.
// - 8-bit mode applies no read interlock.
// - Result-low holds low eight bits or whole 8-bit result.
// - Compare-high bits used only in 10-bit mode with compare on.
// - Compare-low bits checked against low eight result bits in both modes.
// - With compare enabled, complete flag sets only when compare true.
// - Mode code 00 is 8-bit, 10 is 10-bit, others reserved.
// - Writing control one aborts; restarts only with register trigger and channel not all ones.
`timescale 1ns/1ps
`include "adcrc_cfg.svh"
module adcrc_ctrl
  import adcrc_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        hw_trigger_in_i,
  input  wire logic        conv_done_i,
  input  wire logic [9:0]  conv_data_i,
  output logic             conv_start_o,
  output logic             conv_abort_o,
  output logic [4:0]       channel_select_field_o,
  output logic             irq_o
);

  localparam logic [15:0] CONV_CYC = 16'(`ADCRC_CONV_CYC);

  // AXI write channel capture
  logic [7:0]  aw_addr_r;
  logic        aw_have_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        w_have_r;
  logic        wr_fire;
  logic [7:0]  ar_addr;
  logic        rd_fire;

  // Register state
  logic [4:0]  chan_r;
  logic        conv_complete_flag_r;
  logic        trg_sel_r;
  logic        cfe_r;
  logic        ge_r;
  logic        act_r;
  logic [1:0]  mode_r;
  logic [9:0]  cv_r;
  logic [9:0]  res_r;
  logic        lock_r;
  logic [1:0]  ist_r;
  logic [1:0]  imsk_r;
  logic        hwt_prev_r;
  adcrc_state_e state_r;
  logic [15:0] cnt_r;
  logic [9:0]  sample_r;

  logic        wr_sc1;
  logic        hw_edge;
  logic        start;
  logic        finish;
  logic        is10;
  logic        cmp_true;
  logic        keep;
  logic        rd_rh;
  logic        rd_rl;
  logic [7:0]  rd_val;
  logic        rd_ok;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign s_axi_awready_o = !aw_have_r && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_have_r && !s_axi_bvalid_o;
  assign wr_fire         = aw_have_r && w_have_r && !s_axi_bvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign rd_fire         = s_axi_arvalid_i && s_axi_arready_o;
  assign ar_addr         = s_axi_araddr_i;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_have_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr_i;
    end else if (wr_fire) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      w_have_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_have_r <= 1'b1;
      w_data_r <= s_axi_wdata_i;
      w_strb_r <= s_axi_wstrb_i;
    end else if (wr_fire) begin
      w_have_r <= 1'b0;
    end
  end

  // Write response, unmapped addresses answer DECERR
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= 2'b00;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= (aw_addr_r > `ADCRC_OFF_IMSK || aw_addr_r[1:0] != 2'b00) ? 2'b11 : 2'b00;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // Byte lane 0 carries all register data
  logic wr_lane0;
  assign wr_lane0 = wr_fire && w_strb_r[0];
  assign wr_sc1   = wr_lane0 && hit(aw_addr_r, `ADCRC_OFF_SC1);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      chan_r <= `ADCRC_CH_OFF;
    end else if (wr_sc1) begin
      chan_r <= w_data_r[4:0];
    end
  end

  // Active bit not writable; reserved bits dropped
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      trg_sel_r <= 1'b0;
      cfe_r     <= 1'b0;
      ge_r      <= 1'b0;
    end else if (wr_lane0 && hit(aw_addr_r, `ADCRC_OFF_SC2)) begin
      trg_sel_r <= w_data_r[`ADCRC_SC2_TRG_BIT];
      cfe_r     <= w_data_r[`ADCRC_SC2_CFE_BIT];
      ge_r      <= w_data_r[`ADCRC_SC2_GE_BIT];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cv_r   <= {2'b00, `ADCRC_CV_RST};
      mode_r <= `ADCRC_MODE_8BIT;
    end else if (wr_lane0) begin
      if (hit(aw_addr_r, `ADCRC_OFF_CVH)) cv_r[9:8] <= w_data_r[1:0];
      if (hit(aw_addr_r, `ADCRC_OFF_CVL)) cv_r[7:0] <= w_data_r[7:0];
      // Mode field with reserved codes kept as written
      if (hit(aw_addr_r, `ADCRC_OFF_CFG)) mode_r <= w_data_r[`ADCRC_CFG_MODE_LSB +: 2];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      imsk_r <= 2'b00;
    end else if (wr_lane0 && hit(aw_addr_r, `ADCRC_OFF_IMSK)) begin
      imsk_r <= w_data_r[1:0];
    end
  end

  assign hw_edge = hw_trigger_in_i && !hwt_prev_r;
  assign start   = (wr_sc1 && w_data_r[4:0] != `ADCRC_CH_OFF && !trg_sel_r)
                 || (trg_sel_r && hw_edge && chan_r != `ADCRC_CH_OFF && !wr_sc1);
  assign finish  = (state_r == ADCRC_CONV) && conv_done_i && !wr_sc1;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hwt_prev_r <= 1'b0;
    end else begin
      hwt_prev_r <= hw_trigger_in_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      conv_start_o <= 1'b0;
      conv_abort_o <= 1'b0;
    end else begin
      conv_start_o <= start;
      conv_abort_o <= wr_sc1 && act_r;
    end
  end

  assign channel_select_field_o = chan_r;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_r <= ADCRC_IDLE;
      act_r   <= 1'b0;
      cnt_r   <= 16'h0000;
    end else if (start) begin
      state_r <= ADCRC_CONV;
      act_r   <= 1'b1;
      cnt_r   <= CONV_CYC;
    end else if (wr_sc1 || finish) begin
      state_r <= ADCRC_IDLE;
      act_r   <= 1'b0;
    end else if (cnt_r != 16'h0000) begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end

  assign is10 = (mode_r == `ADCRC_MODE_10BIT);
  always_comb begin
    // Top bits forced to zero in 8-bit mode
    sample_r = is10 ? conv_data_i : {2'b00, conv_data_i[7:0]};
  end

  always_comb begin
    if (is10) begin
      cmp_true = ge_r ? (sample_r >= cv_r) : (sample_r < cv_r);
    end else begin
      cmp_true = ge_r ? (sample_r[7:0] >= cv_r[7:0]) : (sample_r[7:0] < cv_r[7:0]);
    end
  end

  // Discard when compare on and false
  assign keep = cfe_r && !cmp_true;

  assign rd_rh = rd_fire && hit(ar_addr, `ADCRC_OFF_RH);
  assign rd_rl = rd_fire && hit(ar_addr, `ADCRC_OFF_RL);

  // Lock on high read in 10-bit mode; none in 8-bit
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lock_r <= 1'b0;
    end else if (rd_rl || !is10) begin
      lock_r <= 1'b0;
    end else if (rd_rh) begin
      lock_r <= 1'b1;
    end
  end

  // Locked results discarded; whole sample stored
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      res_r <= 10'h000;
    end else if (finish && !keep && !(lock_r && is10)) begin
      res_r <= sample_r;
    end
  end

  // Complete flag gated by compare; set wins over clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      conv_complete_flag_r <= 1'b0;
    end else if (finish && !keep) begin
      conv_complete_flag_r <= 1'b1;
    end else if (wr_sc1 || rd_rl) begin
      conv_complete_flag_r <= 1'b0;
    end
  end

  // Sticky events: done, result dropped by lock; set wins over W1C
  logic [1:0] ev;
  logic [1:0] w1c;
  assign ev[`ADCRC_IRQ_DONE] = finish && !keep;
  assign ev[`ADCRC_IRQ_DROP] = finish && !keep && lock_r && is10;
  assign w1c = (wr_lane0 && hit(aw_addr_r, `ADCRC_OFF_IST)) ? w_data_r[1:0] : 2'b00;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ist_r <= 2'b00;
    end else begin
      ist_r <= (ist_r & ~w1c) | ev;
    end
  end

  assign irq_o = |(ist_r & imsk_r);

  always_comb begin
    rd_ok = 1'b1;
    unique case (ar_addr)
      `ADCRC_OFF_SC1:  rd_val = {conv_complete_flag_r, 2'b00, chan_r};
      `ADCRC_OFF_SC2:  rd_val = {act_r, trg_sel_r, cfe_r, ge_r, 4'h0};
      `ADCRC_OFF_RH:   rd_val = {6'h00, res_r[9:8]};
      `ADCRC_OFF_RL:   rd_val = res_r[7:0];
      `ADCRC_OFF_CVH:  rd_val = {6'h00, cv_r[9:8]};
      `ADCRC_OFF_CVL:  rd_val = cv_r[7:0];
      `ADCRC_OFF_CFG:  rd_val = {4'h0, mode_r, 2'b00};
      `ADCRC_OFF_IST:  rd_val = {6'h00, ist_r};
      `ADCRC_OFF_IMSK: rd_val = {6'h00, imsk_r};
      default: begin
        rd_val = 8'h00;
        rd_ok  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= 2'b00;
    end else if (rd_fire) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= {24'h00_0000, rd_val};
      s_axi_rresp_o  <= rd_ok ? 2'b00 : 2'b11;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

endmodule : adcrc_ctrl

// File: adcrc_ctrl_sva.sv
// Bus and conversion pulse checks bound to the result and compare control
`timescale 1ns/1ps
module adcrc_ctrl_sva (
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  s_axi_araddr_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wready_o,
  input wire logic        conv_start_o,
  input wire logic        conv_abort_o,
  input wire logic [4:0]  channel_select_field_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rd_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  a_rd_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read answer dropped or changed");
  a_wr_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write answer dropped or changed");
  a_wr_refuse: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write accepted while answer pending");
  a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid_o)
    else $error("read answer late");
  a_rd_decerr: assert property (s_rd_taken and s_axi_araddr_i > 8'h20
    |=> s_axi_rresp_o == 2'b11 && s_axi_rdata_o == 32'h0)
    else $error("unmapped read not refused");
  a_byte_lane: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_start_pulse: assert property (conv_start_o |=> !conv_start_o)
    else $error("start longer than one cycle");
  a_abort_pulse: assert property (conv_abort_o |=> !conv_abort_o)
    else $error("abort longer than one cycle");
  a_start_chan: assert property (conv_start_o |-> channel_select_field_o != 5'h1f)
    else $error("start with converter off");
endmodule : adcrc_ctrl_sva
bind adcrc_ctrl adcrc_ctrl_sva u_sva (.*);

// File: test_adc_result_compare_control.sv
// Self-checking bench of the result and compare control
`timescale 1ns/1ps
module test_adc_result_compare_control;
  logic        clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, hw = 0, dn = 0;
  logic [7:0]  aa = 0, ra = 0;
  logic [31:0] wd = 0;
  logic [9:0]  cd = 0;
  logic [31:0] lr;
  wire logic   awr, wrd, bv, arr, rv, cs, ca, irq;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [4:0]  ch;
  int          errors = 0, checked = 0, starts = 0, aborts = 0, n0, a0;
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    if (cs === 1'b1) starts++;
    if (ca === 1'b1) aborts++;
  end
  adcrc_ctrl dut (.core_clk_i(clk), .rst_i(rst), .s_axi_awaddr_i(aa), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrd), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
    .s_axi_araddr_i(ra), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .hw_trigger_in_i(hw),
    .conv_done_i(dn), .conv_data_i(cd), .conv_start_o(cs), .conv_abort_o(ca),
    .channel_select_field_o(ch), .irq_o(irq));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
    checked++;
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    aa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wrd === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1);
    lr = {30'h0, bresp};
    br <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    ra <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rdata;
    lr = {30'h0, rresp};
    rr <= 1'b0;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rc
  task automatic go(input logic [7:0] c, input int e);
    n0 = starts;
    wr(8'h00, c);
    repeat (3) @(posedge clk);
    chk(starts - n0, e);
  endtask : go
  task automatic conv(input logic [9:0] d);
    go(8'h03, 1);
    @(posedge clk);
    dn <= 1'b1;
    cd <= d;
    @(posedge clk);
    dn <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : conv
  task automatic t_reset;
    chk(ch, 5'h1f);
    rc(8'h04, 0);
    rc(8'h10, 0);
    rc(8'h18, 0);
    rc(8'h40, 0);
    chk(lr, 3);
    wr(8'h24, 0);
    chk(lr, 3);
  endtask : t_reset
  task automatic t_active;
    go(8'h03, 1);
    rc(8'h04, 8'h80);
    wr(8'h04, 8'h80);
    rc(8'h04, 8'h80);
    a0 = aborts;
    go(8'h03, 1);
    chk(aborts - a0, 1);
    conv(10'h011);
    rc(8'h04, 0);
    go(8'h1f, 0);
  endtask : t_active
  task automatic t_mode8;
    wr(8'h1c, 3);
    wr(8'h20, 1);
    chk(lr, 0);
    conv(10'h3a5);
    chk(irq, 1);
    rc(8'h08, 0);
    rc(8'h0c, 8'ha5);
    wr(8'h1c, 1);
    rc(8'h1c, 0);
    chk(irq, 0);
    wr(8'h20, 0);
  endtask : t_mode8
  task automatic t_lock;
    wr(8'h18, 8'h08);
    conv(10'h2c3);
    rc(8'h08, 2);
    conv(10'h155);
    rc(8'h0c, 8'hc3);
    rc(8'h1c, 3);
    conv(10'h155);
    rc(8'h08, 1);
    rc(8'h0c, 8'h55);
    wr(8'h18, 0);
    conv(10'h2c3);
    rc(8'h08, 0);
    conv(10'h1aa);
    rc(8'h0c, 8'haa);
  endtask : t_lock
  task automatic t_cmp;
    logic [31:0] d;
    wr(8'h18, 8'h08);
    wr(8'h10, 1);
    wr(8'h14, 0);
    wr(8'h04, 8'h20);
    conv(10'h0ff);
    rd(8'h00, d);
    chk(d & 8'h80, 8'h80);
    rc(8'h0c, 8'hff);
    conv(10'h200);
    rd(8'h00, d);
    chk(d & 8'h80, 0);
    rc(8'h0c, 8'hff);
    wr(8'h04, 8'h30);
    conv(10'h100);
    rc(8'h08, 1);
    rc(8'h0c, 0);
    wr(8'h04, 0);
    conv(10'h2ff);
    rc(8'h0c, 8'hff);
    wr(8'h18, 0);
    wr(8'h14, 8'h80);
    wr(8'h04, 8'h30);
    conv(10'h090);
    rc(8'h0c, 8'h90);
    conv(10'h07f);
    rc(8'h0c, 8'h90);
  endtask : t_cmp
  task automatic t_hw;
    wr(8'h04, 8'h40);
    go(8'h02, 0);
    @(posedge clk);
    hw <= 1'b1;
    repeat (3) @(posedge clk);
    chk(starts - n0, 1);
    hw <= 1'b0;
    dn <= 1'b1;
    @(posedge clk);
    dn <= 1'b0;
    wr(8'h04, 0);
  endtask : t_hw
  task automatic end_of_test;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    #200000;
    errors++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_active();
    t_mode8();
    t_lock();
    t_cmp();
    t_hw();
    end_of_test();
  end
endmodule : test_adc_result_compare_control
